// >>> rtl/fast_outputs.sv
/*
 * Two fast outputs: drive bit, PWM, counter match or stepper.
 * Assumes controller state and counter match levels come from
 * logic on clk; registers reached over a plain strobe port.
 */
// The strobed register port and the register addresses were left to the implementer.
// What this block does
// - Two outputs, each in one of four modes
// - Normal mode follows its drive bit
// - Own PWM channel, own frequency and duty
// - Duty 0..32000; 0 off, 32000 on
// - Frequency in hertz, changeable at run time
// - PWM low until frequency and duty non-zero
// - Stop mode: hold level or stop settings
// - Zero stop frequency or duty keeps low
// - Match mode follows counter compare level
// - Four-counter setup: only stepper one works
// - Five stepper settings captured at start
// - Ramping needs start frequency within run
// - Run frequency non-zero, at most variant ceiling
// - Accel count ramps up; 1 is error
// - Run count any value; zero skips
// - Decel count ramps down; 1 is error
// - Ready when idle or move finished
// - Error on bad settings or abort
// - Clearing start bit mid-move aborts, errors
// - Stop mode kills move and its count
`timescale 1ns/1ps
module fast_outputs #(
    parameter logic [31:0] RUN_MAX = hso_pkg::RUN_MAX_STD
) (
    // Clock, reset, enable
    input  wire logic                      clk,
    input  wire logic                      rst,
    input  wire logic                      ce,
    // Register port
    input  wire logic [hso_pkg::ADDR_W-1:0] addr,
    input  wire logic [31:0]               wdata,
    input  wire logic                      wr,
    input  wire logic                      rd,
    output logic      [31:0]               rdata,
    // Controller state
    input  wire logic                      stop_mode,
    input  wire logic                      download,
    input  wire logic                      four_counter,
    // Counter compare levels
    input  wire logic [1:0]                match_level,
    // Fast outputs
    output logic                           fast_output_one,
    output logic                           fast_output_two
);
    localparam int PH = hso_pkg::PH_W;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0][1:0]             mode;
        logic [1:0][31:0]            duty;
        logic [1:0][31:0]            freq;
        logic [1:0][31:0]            sduty;
        logic [1:0][31:0]            sfreq;
        logic [1:0][31:0]            fs;
        logic [1:0][31:0]            fr;
        logic [1:0][31:0]            na;
        logic [1:0][31:0]            nr;
        logic [1:0][31:0]            nd;
        logic [1:0][31:0]            cfs;
        logic [1:0][31:0]            cfr;
        logic [1:0][31:0]            cna;
        logic [1:0][31:0]            cnr;
        logic [1:0][31:0]            cnd;
        logic [1:0]                  shold;
        logic [1:0]                  drive;
        logic [1:0]                  start;
        logic [1:0]                  start_q;
        logic [1:0]                  armed;
        logic [1:0]                  err;
        logic [1:0]                  outv;
        hso_pkg::step_state_t [1:0]  st;
        logic [1:0][PH-1:0]          ph;
        logic [1:0][33:0]            k;
        logic [31:0]                 rdata;
    } state_t;

    state_t st_reg;
    state_t st_next;
    state_t r;

    assign r = st_reg;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Phase accumulator step; top bit flags a period wrap
    function automatic logic [PH:0] ph_step(
        input logic [PH-1:0] p,
        input logic [31:0]   f
    );
        logic [32:0] s;
        s = 33'(p) + 33'((f > hso_pkg::HALF_HZ) ? hso_pkg::HALF_HZ : f);
        if (s >= 33'(hso_pkg::REF_HZ)) begin
            s = s - 33'(hso_pkg::REF_HZ);
            ph_step = {1'b1, s[PH-1:0]};
        end else begin
            ph_step = {1'b0, s[PH-1:0]};
        end
    endfunction

    // High part of the period in proportion to duty
    function automatic logic duty_hi(
        input logic [PH-1:0] p,
        input logic [31:0]   d
    );
        duty_hi = 64'(p) * 64'(hso_pkg::DUTY_FULL)
                < 64'(d) * 64'(hso_pkg::REF_HZ);
    endfunction

    // Frequency of step k along the ramp profile
    function automatic logic [31:0] step_freq(
        input logic [33:0] k,
        input logic [31:0] fs,
        input logic [31:0] fr,
        input logic [31:0] a,
        input logic [31:0] rn,
        input logic [31:0] dn
    );
        logic [33:0] j;
        logic [63:0] q;
        j = '0;
        q = '0;
        if (k < 34'(a)) begin
            q = 64'(fr - fs) * 64'(k) / 64'(a - 32'h1);
            step_freq = fs + q[31:0];
        end else if (k < 34'(a) + 34'(rn)) begin
            step_freq = fr;
        end else begin
            j = k - 34'(a) - 34'(rn);
            q = 64'(fr - fs) * 64'(j) / 64'(dn - 32'h1);
            step_freq = fr - q[31:0];
        end
    endfunction

    function automatic logic bad_params(
        input logic [31:0] fs,
        input logic [31:0] fr,
        input logic [31:0] a,
        input logic [31:0] d
    );
        bad_params = fr == '0 || fr > RUN_MAX
                  || a == 32'h1 || d == 32'h1
                  || ((a != '0 || d != '0)
                      && (fs == '0 || fs > fr));
    endfunction

    // ------------------------------------------------------------
    // Per-channel terms
    // ------------------------------------------------------------
    logic [1:0][31:0] pf;
    logic [1:0][31:0] pd;
    logic [1:0][PH:0] pnx;
    logic [1:0]       pwm_lvl;
    logic [1:0][31:0] sfq;
    logic [1:0][PH:0] snx;
    logic [1:0]       stp_lvl;
    logic [1:0]       step_ok;
    logic [1:0]       go;
    logic [1:0]       bad;
    logic [1:0]       ready;
    logic [1:0][33:0] ltot;
    logic [1:0][33:0] ctot;

    for (genvar c = 0; c < 2; c++) begin : g_ch
        // Settings in force: run or stop set
        assign pf[c] = stop_mode ? r.sfreq[c] : r.freq[c];
        assign pd[c] = stop_mode ? r.sduty[c] : r.duty[c];
        assign pnx[c] = ph_step(r.ph[c], pf[c]);
        assign pwm_lvl[c] = !download && pd[c] != '0
            && (stop_mode ? pf[c] != '0
                : r.armed[c] && (pf[c] != '0
                    || pd[c] >= 32'(hso_pkg::DUTY_FULL)))
            && duty_hi(r.ph[c], pd[c]);
        assign sfq[c] = step_freq(r.k[c], r.cfs[c], r.cfr[c],
                                  r.cna[c], r.cnr[c], r.cnd[c]);
        assign snx[c] = ph_step(r.ph[c], sfq[c]);
        assign stp_lvl[c] = !stop_mode
            && r.st[c] == hso_pkg::S_MOVE
            && 32'(r.ph[c]) < hso_pkg::HALF_HZ;
        assign step_ok[c] = (c == 0) || !four_counter;
        assign go[c] = r.mode[c] == hso_pkg::MODE_STEP && step_ok[c]
            && r.start[c] && !r.start_q[c] && !stop_mode
            && r.st[c] != hso_pkg::S_MOVE;
        assign bad[c] = bad_params(r.fs[c], r.fr[c],
                                   r.na[c], r.nd[c]);
        assign ready[c] = step_ok[c]
            && r.st[c] != hso_pkg::S_MOVE;
        assign ltot[c] = 34'(r.na[c]) + 34'(r.nr[c]) + 34'(r.nd[c]);
        assign ctot[c] = 34'(r.cna[c]) + 34'(r.cnr[c]) + 34'(r.cnd[c]);
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        st_next = r;
        st_next.rdata = '0;
        for (int c = 0; c < 2; c++) begin
            st_next.start_q[c] = r.start[c];
            if (download) begin
                st_next.armed[c] = 1'b0;
            end else if (r.freq[c] != '0 && r.duty[c] != '0) begin
                st_next.armed[c] = 1'b1;
            end
            // Output select, one mode per channel
            unique case (r.mode[c])
                hso_pkg::MODE_NORMAL: begin
                    st_next.outv[c] = r.drive[c];
                end
                hso_pkg::MODE_PWM: begin
                    st_next.outv[c] = (stop_mode && r.shold[c])
                        ? r.outv[c] : pwm_lvl[c];
                end
                hso_pkg::MODE_MATCH: begin
                    st_next.outv[c] = match_level[c];
                end
                hso_pkg::MODE_STEP: begin
                    st_next.outv[c] = stp_lvl[c];
                end
            endcase
            if (r.mode[c] == hso_pkg::MODE_PWM
                && !(stop_mode && r.shold[c])) begin
                st_next.ph[c] = pnx[c][PH-1:0];
            end
            // Stepper sequence
            unique case (r.st[c])
                hso_pkg::S_IDLE, hso_pkg::S_DONE: begin
                    if (r.st[c] == hso_pkg::S_DONE && !r.start[c]) begin
                        st_next.st[c] = hso_pkg::S_IDLE;
                    end
                    if (go[c]) begin
                        st_next.err[c] = bad[c];
                        if (!bad[c]) begin
                            st_next.cfs[c] = r.fs[c];
                            st_next.cfr[c] = r.fr[c];
                            st_next.cna[c] = r.na[c];
                            st_next.cnr[c] = r.nr[c];
                            st_next.cnd[c] = r.nd[c];
                            st_next.k[c] = '0;
                            st_next.ph[c] = '0;
                            st_next.st[c] = (ltot[c] == '0)
                                ? hso_pkg::S_DONE : hso_pkg::S_MOVE;
                        end
                    end
                end
                hso_pkg::S_MOVE: begin
                    if (stop_mode
                        || r.mode[c] != hso_pkg::MODE_STEP) begin
                        st_next.st[c] = hso_pkg::S_IDLE;
                        st_next.k[c] = '0;
                        st_next.ph[c] = '0;
                    end else if (!r.start[c]) begin
                        st_next.err[c] = 1'b1;
                        st_next.st[c] = hso_pkg::S_IDLE;
                    end else begin
                        st_next.ph[c] = snx[c][PH-1:0];
                        if (snx[c][PH]) begin
                            if (r.k[c] + 34'h1 >= ctot[c]) begin
                                st_next.st[c] = hso_pkg::S_DONE;
                            end else begin
                                st_next.k[c] = r.k[c] + 34'h1;
                            end
                        end
                    end
                end
                default: begin
                    st_next.st[c] = hso_pkg::S_IDLE;
                end
            endcase
        end
        // Register writes
        if (wr) begin
            case (addr[3:0])
                hso_pkg::REG_MODE: begin
                    st_next.mode[addr[4]] = wdata[1:0];
                end
                hso_pkg::REG_DUTY: begin
                    st_next.duty[addr[4]] = wdata;
                end
                hso_pkg::REG_FREQ: begin
                    st_next.freq[addr[4]] = wdata;
                end
                hso_pkg::REG_SDUTY: begin
                    st_next.sduty[addr[4]] = wdata;
                end
                hso_pkg::REG_SFREQ: begin
                    st_next.sfreq[addr[4]] = wdata;
                end
                hso_pkg::REG_SHOLD: begin
                    st_next.shold[addr[4]] = wdata[0];
                end
                hso_pkg::REG_FSTART: begin
                    st_next.fs[addr[4]] = wdata;
                end
                hso_pkg::REG_FRUN: begin
                    st_next.fr[addr[4]] = wdata;
                end
                hso_pkg::REG_NACC: begin
                    st_next.na[addr[4]] = wdata;
                end
                hso_pkg::REG_NRUN: begin
                    st_next.nr[addr[4]] = wdata;
                end
                hso_pkg::REG_NDEC: begin
                    st_next.nd[addr[4]] = wdata;
                end
                hso_pkg::REG_CTRL: begin
                    st_next.drive[addr[4]] = wdata[hso_pkg::CTL_DRIVE];
                    st_next.start[addr[4]] = wdata[hso_pkg::CTL_START];
                end
                default: begin
                end
            endcase
        end
        // Register reads, answered next cycle
        if (rd) begin
            case (addr[3:0])
                hso_pkg::REG_MODE: begin
                    st_next.rdata = 32'(r.mode[addr[4]]);
                end
                hso_pkg::REG_DUTY: begin
                    st_next.rdata = r.duty[addr[4]];
                end
                hso_pkg::REG_FREQ: begin
                    st_next.rdata = r.freq[addr[4]];
                end
                hso_pkg::REG_SDUTY: begin
                    st_next.rdata = r.sduty[addr[4]];
                end
                hso_pkg::REG_SFREQ: begin
                    st_next.rdata = r.sfreq[addr[4]];
                end
                hso_pkg::REG_SHOLD: begin
                    st_next.rdata = 32'(r.shold[addr[4]]);
                end
                hso_pkg::REG_FSTART: begin
                    st_next.rdata = r.fs[addr[4]];
                end
                hso_pkg::REG_FRUN: begin
                    st_next.rdata = r.fr[addr[4]];
                end
                hso_pkg::REG_NACC: begin
                    st_next.rdata = r.na[addr[4]];
                end
                hso_pkg::REG_NRUN: begin
                    st_next.rdata = r.nr[addr[4]];
                end
                hso_pkg::REG_NDEC: begin
                    st_next.rdata = r.nd[addr[4]];
                end
                hso_pkg::REG_CTRL: begin
                    st_next.rdata[hso_pkg::CTL_DRIVE] = r.drive[addr[4]];
                    st_next.rdata[hso_pkg::CTL_START] = r.start[addr[4]];
                end
                hso_pkg::REG_STATUS: begin
                    st_next.rdata[hso_pkg::STS_READY] = ready[addr[4]];
                    st_next.rdata[hso_pkg::STS_ERR] = r.err[addr[4]];
                    st_next.rdata[hso_pkg::STS_OUT] = r.outv[addr[4]];
                    st_next.rdata[hso_pkg::STS_ARMED] = r.armed[addr[4]];
                end
                default: begin
                end
            endcase
        end
        if (!ce) begin
            st_next = r;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign rdata = r.rdata;
    assign fast_output_one = r.outv[0];
    assign fast_output_two = r.outv[1];

    // ------------------------------------------------------------
    // Checks; PWM ones watch output two
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence start_ok;
        ce && go[0] && !bad[0] && ltot[0] != '0;
    endsequence

    sequence abort_seen;
        ce && r.st[0] == hso_pkg::S_MOVE && !stop_mode
        && r.mode[0] == hso_pkg::MODE_STEP ##0 !r.start[0];
    endsequence

    normal_follow_a: assert property (
        ce && r.mode[0] == hso_pkg::MODE_NORMAL
        |=> fast_output_one == $past(r.drive[0]))
        else $error("normal output differs from drive bit");

    pwm_download_a: assert property (
        ce && download && !stop_mode
        && r.mode[1] == hso_pkg::MODE_PWM |=> !fast_output_two)
        else $error("pwm output high during download");

    stop_zero_a: assert property (
        ce && stop_mode && r.mode[1] == hso_pkg::MODE_PWM
        && !r.shold[1] && (r.sfreq[1] == '0 || r.sduty[1] == '0)
        |=> !fast_output_two)
        else $error("pwm output high with zero stop setting");

    duty_full_a: assert property (
        ce && !download && !stop_mode && r.armed[1]
        && r.mode[1] == hso_pkg::MODE_PWM
        && r.duty[1] >= 32'(hso_pkg::DUTY_FULL) |=> fast_output_two)
        else $error("full duty output not high");

    start_cap_a: assert property (
        start_ok |=> r.st[0] == hso_pkg::S_MOVE && !r.err[0]
        && r.cfr[0] == $past(r.fr[0]))
        else $error("start did not capture settings");

    abort_err_a: assert property (
        abort_seen |=> r.err[0] && r.st[0] == hso_pkg::S_IDLE)
        else $error("abort did not flag error");

    stop_kill_a: assert property (
        ce && stop_mode && r.st[0] == hso_pkg::S_MOVE
        && r.mode[0] == hso_pkg::MODE_STEP
        |=> !fast_output_one && r.k[0] == '0
        && r.st[0] == hso_pkg::S_IDLE)
        else $error("stop did not kill move");

    accel_one_a: assert property (
        ce && go[0] && r.na[0] == 32'h0000_0001
        |=> r.err[0] && r.st[0] != hso_pkg::S_MOVE)
        else $error("accel count of one accepted");

    run_max_a: assert property (
        ce && go[0] && r.fr[0] > RUN_MAX |=> r.err[0])
        else $error("run frequency above ceiling accepted");
endmodule

// >>> rtl/hso_pkg.sv
/*
 * Constants and types of the two-channel fast output block.
 * Assumes the 100 MHz system clock is also the pulse reference.
 */
package hso_pkg;
    // ------------------------------------------------------------
    // Reference clock and scales
    // ------------------------------------------------------------
    localparam logic [31:0] REF_HZ    = 32'h05F5_E100;
    localparam logic [31:0] HALF_HZ   = 32'h02FA_F080;
    localparam logic [15:0] DUTY_FULL = 16'h7D00;
    localparam int          PH_W      = 27;
    localparam int          ADDR_W    = 5;

    // ------------------------------------------------------------
    // Run frequency ceilings per output variant
    // ------------------------------------------------------------
    localparam logic [31:0] RUN_MAX_STD = 32'h0000_1388;
    localparam logic [31:0] RUN_MAX_24V = 32'h0006_1A80;
    localparam logic [31:0] RUN_MAX_5V  = 32'h000F_4240;

    // ------------------------------------------------------------
    // Register indices inside one channel (address bit 4 = channel)
    // ------------------------------------------------------------
    localparam logic [3:0] REG_MODE   = 4'h0;
    localparam logic [3:0] REG_DUTY   = 4'h1;
    localparam logic [3:0] REG_FREQ   = 4'h2;
    localparam logic [3:0] REG_SDUTY  = 4'h3;
    localparam logic [3:0] REG_SFREQ  = 4'h4;
    localparam logic [3:0] REG_SHOLD  = 4'h5;
    localparam logic [3:0] REG_FSTART = 4'h6;
    localparam logic [3:0] REG_FRUN   = 4'h7;
    localparam logic [3:0] REG_NACC   = 4'h8;
    localparam logic [3:0] REG_NRUN   = 4'h9;
    localparam logic [3:0] REG_NDEC   = 4'hA;
    localparam logic [3:0] REG_CTRL   = 4'hB;
    localparam logic [3:0] REG_STATUS = 4'hC;

    // Bit positions
    localparam int CTL_DRIVE = 0;
    localparam int CTL_START = 1;
    localparam int STS_READY = 0;
    localparam int STS_ERR   = 1;
    localparam int STS_OUT   = 2;
    localparam int STS_ARMED = 3;

    typedef enum logic [1:0] {
        MODE_NORMAL, MODE_PWM, MODE_MATCH, MODE_STEP
    } mode_t;

    typedef enum logic [1:0] {S_IDLE, S_MOVE, S_DONE} step_state_t;
endpackage

// >>> testbench/high_speed_output_pwm_stepper_bench.sv
/*
 * Self-checking bench of the two fast outputs.
 * Assumes fast_outputs and pulse_load; one 100 MHz clock.
 */
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin \
    miscompares++; $display("[ERR] %0t got %h want %h", $time, a, b); end end
module high_speed_output_pwm_stepper_bench;
    typedef struct packed {
        logic       ch;
        logic [1:0] mode;
        logic       drive;
        logic [1:0] ml;
        logic       exp;
    } row_t;
    row_t rows[6] = '{
        '{1'b0, 2'h0, 1'b1, 2'h0, 1'b1}, '{1'b0, 2'h0, 1'b0, 2'h3, 1'b0},
        '{1'b0, 2'h2, 1'b0, 2'h1, 1'b1}, '{1'b0, 2'h2, 1'b1, 2'h2, 1'b0},
        '{1'b1, 2'h0, 1'b1, 2'h0, 1'b1}, '{1'b1, 2'h2, 1'b0, 2'h2, 1'b1}};
    logic [31:0] bad[6][5] = '{
        '{32'h0, 32'h000F_4240, 32'h2, 32'h1, 32'h0},
        '{32'h000F_4240, 32'h0007_A120, 32'h2, 32'h0, 32'h2},
        '{32'h0007_A120, 32'h000F_4240, 32'h1, 32'h0, 32'h0},
        '{32'h0007_A120, 32'h000F_4240, 32'h0, 32'h0, 32'h1},
        '{32'h0, 32'h0, 32'h0, 32'h1, 32'h0},
        '{32'h0, 32'h000F_4241, 32'h0, 32'h1, 32'h0}};
    logic [31:0] good[5] = '{32'h0007_A120, 32'h000F_4240, 32'h2, 32'h3,
        32'h2};
    logic [31:0] long_run[5] = '{32'h0, 32'h000F_4240, 32'h0, 32'h100, 32'h0};
    logic        clk;
    logic        rst = 1'b1, ce = 1'b1, wr = 1'b0, rd = 1'b0, clr = 1'b1;
    logic        stop_mode = 1'b0, download = 1'b0, four_counter = 1'b0;
    logic [4:0]  addr = 5'h00;
    logic [31:0] wdata = 32'h0000_0000, rdata, rv;
    logic [1:0]  match_level = 2'h0;
    logic        out1, out2;
    logic [15:0] r1, h1, r2, h2;
    int          miscompares = 0, tests_run = 0, cycles = 0;

    // Fastest variant ceiling keeps step periods short
    fast_outputs #(.RUN_MAX(hso_pkg::RUN_MAX_5V)) uut (.clk(clk), .rst(rst),
        .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .stop_mode(stop_mode), .download(download),
        .four_counter(four_counter), .match_level(match_level),
        .fast_output_one(out1), .fast_output_two(out2));
    pulse_load load_one (.clk(clk), .clear(clr), .level(out1), .rises(r1),
        .highs(h1));
    pulse_load load_two (.clk(clk), .clear(clr), .level(out2), .rises(r2),
        .highs(h2));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wreg(input logic ch, input logic [3:0] i, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= {ch, i};
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic ch, input logic [3:0] i);
        @(posedge clk);
        rd <= 1'b1;
        addr <= {ch, i};
        @(posedge clk);
        rd <= 1'b0;
        #1 rv = rdata;
    endtask
    task automatic measure(input int n);
        cyc(4);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        cyc(n);
        #1;
    endtask
    task automatic go(input logic [31:0] p[5]);
        for (int k = 0; k < 5; k++) wreg(1'b0, hso_pkg::REG_FSTART + 4'(k), p[k]);
        wreg(1'b0, hso_pkg::REG_CTRL, 32'h0000_0002);
        cyc(4);
    endtask
    task automatic wait_ready();
        for (int k = 0; k < 100; k++) begin
            rreg(1'b0, hso_pkg::REG_STATUS);
            if (rv[0] === 1'b1) break;
            cyc(20);
        end
    endtask
    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            miscompares++;
            wrap_up();
        end
    end

    initial begin
        cyc(16);
        rst <= 1'b0;
        rreg(1'b0, hso_pkg::REG_STATUS);
        `CHK(rv[1:0], 2'b01)
        `CHK({out1, out2}, 2'b00)
        // ----------------------------------------------------------------
        // Normal and match rows
        // ----------------------------------------------------------------
        foreach (rows[i]) begin
            wreg(rows[i].ch, hso_pkg::REG_MODE, {30'h0, rows[i].mode});
            wreg(rows[i].ch, hso_pkg::REG_CTRL, {31'h0, rows[i].drive});
            match_level <= rows[i].ml;
            cyc(3);
            #1 `CHK(rows[i].ch ? out2 : out1, rows[i].exp)
        end
        // ----------------------------------------------------------------
        // PWM on output two
        // ----------------------------------------------------------------
        wreg(1'b1, hso_pkg::REG_MODE, 32'h0000_0001);
        wreg(1'b1, hso_pkg::REG_DUTY, 32'h0000_1F40);
        measure(200);
        `CHK(h2, 16'h0000)
        wreg(1'b1, hso_pkg::REG_FREQ, 32'h000F_4240);
        measure(200);
        `CHK(h2 >= 16'h0030 && h2 <= 16'h0034, 1'b1)
        wreg(1'b1, hso_pkg::REG_FREQ, 32'h0007_A120);
        measure(400);
        `CHK(h2 >= 16'h0062 && h2 <= 16'h0066, 1'b1)
        wreg(1'b1, hso_pkg::REG_DUTY, 32'h0000_7D00);
        measure(100);
        `CHK(h2, 16'h0064)
        // Write with enable low must not land
        @(posedge clk) ce <= 1'b0;
        wreg(1'b1, hso_pkg::REG_DUTY, 32'h0000_0000);
        ce <= 1'b1;
        measure(100);
        `CHK(h2, 16'h0064)
        wreg(1'b1, hso_pkg::REG_DUTY, 32'h0000_0000);
        measure(100);
        `CHK(h2, 16'h0000)
        wreg(1'b1, hso_pkg::REG_DUTY, 32'h0000_3E80);
        wreg(1'b1, hso_pkg::REG_SDUTY, 32'h0000_7D00);
        @(posedge clk) stop_mode <= 1'b1;
        measure(100);
        `CHK(h2, 16'h0000)
        wreg(1'b1, hso_pkg::REG_SFREQ, 32'h000F_4240);
        measure(100);
        `CHK(h2, 16'h0064)
        wreg(1'b1, hso_pkg::REG_SHOLD, 32'h0000_0001);
        wreg(1'b1, hso_pkg::REG_SDUTY, 32'h0000_0000);
        measure(100);
        `CHK(h2, 16'h0064)
        @(posedge clk) stop_mode <= 1'b0;
        download <= 1'b1;
        measure(100);
        `CHK(h2, 16'h0000)
        rreg(1'b1, hso_pkg::REG_STATUS);
        `CHK(rv[3], 1'b0)
        @(posedge clk) download <= 1'b0;
        rreg(1'b1, hso_pkg::REG_STATUS);
        `CHK(rv[3], 1'b1)
        // ----------------------------------------------------------------
        // Stepper on output one
        // ----------------------------------------------------------------
        wreg(1'b0, hso_pkg::REG_MODE, 32'h0000_0003);
        foreach (bad[i]) begin
            go(bad[i]);
            rreg(1'b0, hso_pkg::REG_STATUS);
            `CHK(rv[1], 1'b1)
            wreg(1'b0, hso_pkg::REG_CTRL, 32'h0000_0000);
        end
        measure(0);
        go(good);
        wreg(1'b0, hso_pkg::REG_NRUN, 32'h0000_0100);
        rreg(1'b0, hso_pkg::REG_STATUS);
        `CHK(rv[1:0], 2'b00)
        wait_ready();
        `CHK(rv[1:0], 2'b01)
        `CHK(r1, 16'h0007)
        wreg(1'b0, hso_pkg::REG_CTRL, 32'h0000_0000);
        go(long_run);
        cyc(150);
        wreg(1'b0, hso_pkg::REG_CTRL, 32'h0000_0000);
        cyc(2);
        rreg(1'b0, hso_pkg::REG_STATUS);
        `CHK(rv[1:0], 2'b11)
        go(long_run);
        cyc(150);
        @(posedge clk) stop_mode <= 1'b1;
        cyc(2);
        #1 `CHK(out1, 1'b0)
        measure(200);
        `CHK(h1, 16'h0000)
        @(posedge clk) stop_mode <= 1'b0;
        rreg(1'b0, hso_pkg::REG_STATUS);
        `CHK(rv[1:0], 2'b01)
        wreg(1'b0, hso_pkg::REG_CTRL, 32'h0000_0000);
        @(posedge clk) four_counter <= 1'b1;
        wreg(1'b1, hso_pkg::REG_MODE, 32'h0000_0003);
        rreg(1'b1, hso_pkg::REG_STATUS);
        `CHK(rv[0], 1'b0)
        wrap_up();
    end
endmodule

// >>> testbench/pulse_load.sv
/*
 * Load on one fast output: counts rising edges and high cycles.
 * Assumes the output is registered on clk; clear restarts counts.
 */
`timescale 1ns/1ps
module pulse_load (
    // Clock and control
    input  wire logic        clk,
    input  wire logic        clear,
    // Drive from the block
    input  wire logic        level,
    // Observed counts
    output logic      [15:0] rises,
    output logic      [15:0] highs
);
    logic level_reg;

    always_ff @(posedge clk) begin
        level_reg <= level;
        if (clear) begin
            rises <= 16'h0000;
            highs <= 16'h0000;
        end else begin
            rises <= rises + 16'(level & ~level_reg);
            highs <= highs + 16'(level);
        end
    end
endmodule
